// ===== hw/i2sf_status.sv
// Two-wire bus status-flag block: bus tracking, flags and register port
//
// Summary of operation
// - Master transmit: capture slave ACK/NACK into ack_result
// - master_tx_active spans eight bits plus acknowledge
// - Status bits 13 to 11 read zero
// - Collision during master operation sets bus_collision
// - General call match sets flag, Stop clears
// - Second 10-bit address byte match sets flag
// - Transmit write while busy fails, sets write_collision
// - Byte arriving on full buffer sets overflow
// - Address match clears, data byte sets data flag
// - Stop sets, Start or Repeated Start clears
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "i2sf_regs.svh"
module i2sf_status
   import i2sf_pkg::*;
#(
   parameter int SYNC_STAGES = 2
)
(
   input  wire logic                     core_clk_i,  // Core clock, 25 MHz
   input  wire logic                     rst_i,       // Async reset
   input  wire logic                     scl_i,       // Bus clock pin level
   input  wire logic                     sda_i,       // Bus data pin level
   output logic                          sda_o,       // Data drive value
   output logic                          sda_oe_o,    // Data drive enable
   input  wire logic [`I2SF_ADDR_W-1:0]  reg_addr_i,  // Register index
   input  wire logic [`I2SF_DATA_W-1:0]  reg_wdata_i, // Write data
   input  wire logic                     reg_wr_i,    // Write strobe
   input  wire logic                     reg_rd_i,    // Read strobe
   output logic      [`I2SF_DATA_W-1:0]  reg_rdata_o, // Read data, next cycle
   output logic                          irq_o        // Level interrupt
);
   generate
      if (SYNC_STAGES < 2)
      begin : g_bad
         $error("i2sf_status needs at least two sync stages");
      end
   endgenerate

   i2sf_line_t  pin_raw;
   i2sf_line_t  pin_s;
   i2sf_cond_t  cnd;
   i2sf_state_t state_ff;
   i2sf_evt_t   evt;

   logic [`I2SF_CTRL_W-1:0] ctrl_ff;
   logic [`I2SF_OWN_W-1:0]  own_ff;
   logic [3:0]              cnt_ff;
   logic [7:0]              rx_sh_ff;
   logic [7:0]              rx_buf_ff;
   logic                    rx_full_ff;
   logic [7:0]              tx_sh_ff;
   logic                    tx_act_ff;
   logic                    ack_ff;
   logic                    bcl_ff;
   logic                    gc_ff;
   logic                    ten_bit_match_ff;
   logic                    write_collision_ff;
   logic                    ov_ff;
   logic                    da_ff;
   logic                    p_ff;
   logic                    oe_ff;
   logic [`I2SF_EVT_W-1:0]  istat_ff;
   logic [`I2SF_EVT_W-1:0]  ien_ff;
   logic [`I2SF_DATA_W-1:0] rdata_ff;
   logic [`I2SF_DATA_W-1:0] status_vec;

   logic wr_status;
   logic wr_tx;
   logic tx_go;
   logic rd_rx;
   logic byte_done;
   logic ack_end;
   logic is_master;
   logic gc_hit;
   logic m7_hit;
   logic hdr_hit;
   logic m10_hit;
   logic addr_hit;
   logic data_hit;
   logic do_ack;
   logic collide;
   logic frame_edge;

   assign pin_raw = '{scl: scl_i, sda: sda_i};

   i2sf_sync #(
      .W      (2),
      .STAGES (SYNC_STAGES)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .async_i    (pin_raw),
      .sync_o     (pin_s)
   );

   i2sf_cond u_cond (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .line_i     (pin_s),
      .cond_o     (cnd)
   );

   assign wr_status  = reg_wr_i && (reg_addr_i == `I2SF_REG_STATUS);
   assign wr_tx      = reg_wr_i && (reg_addr_i == `I2SF_REG_TX);
   assign rd_rx      = reg_rd_i && (reg_addr_i == `I2SF_REG_RX);
   assign is_master  = ctrl_ff[`I2SF_CTRL_MASTER];
   // Slave transmit is not served here, so a write outside master is dropped
   assign tx_go      = wr_tx && !tx_act_ff && is_master;
   assign frame_edge = cnd.start || cnd.stop;
   assign byte_done  = cnd.fall && (cnt_ff == `I2SF_CNT_BYTE);
   assign ack_end    = cnd.fall && (cnt_ff == `I2SF_CNT_ACK);

   // Our own released one is read back low: someone else owns the wire
   assign collide = cnd.rise && tx_act_ff && !oe_ff && !pin_s.sda
                    && (cnt_ff < `I2SF_CNT_BYTE);

   // Address decoding; bytes we send ourselves are never parsed as slave
   assign gc_hit   = (state_ff == ST_ADDR) && !is_master
                     && ctrl_ff[`I2SF_CTRL_GCEN]
                     && (rx_sh_ff == `I2SF_GC_ADDR);
   assign m7_hit   = (state_ff == ST_ADDR) && !is_master
                     && !ctrl_ff[`I2SF_CTRL_TEN]
                     && (rx_sh_ff[7:1] == own_ff[6:0]);
   assign hdr_hit  = (state_ff == ST_ADDR) && !is_master
                     && ctrl_ff[`I2SF_CTRL_TEN]
                     && (rx_sh_ff[7:3] == `I2SF_TEN_HDR)
                     && (rx_sh_ff[2:1] == own_ff[9:8]);
   assign m10_hit  = (state_ff == ST_ADDR2) && (rx_sh_ff == own_ff[7:0]);
   assign addr_hit = gc_hit || m7_hit || hdr_hit || m10_hit;
   assign data_hit = (state_ff == ST_DATA);
   // Overflowing byte is refused with a NACK so the master can retry
   assign do_ack   = addr_hit || (data_hit && !rx_full_ff);

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         cnt_ff <= `I2SF_CNT_ZERO;
      else if (frame_edge)
         cnt_ff <= `I2SF_CNT_ZERO;
      else if (cnd.rise && cnt_ff < `I2SF_CNT_ACK)
         cnt_ff <= cnt_ff + 4'h1;
      else if (ack_end)
         cnt_ff <= `I2SF_CNT_ZERO;
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         rx_sh_ff <= 8'h00;
      else if (cnd.rise && cnt_ff < `I2SF_CNT_BYTE)
         rx_sh_ff <= {rx_sh_ff[6:0], pin_s.sda};
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         state_ff <= ST_IDLE;
      else if (cnd.start)
         state_ff <= ST_ADDR;
      else if (cnd.stop)
         state_ff <= ST_IDLE;
      else if (byte_done)
      begin
         unique case (state_ff)
            ST_ADDR:
               if (gc_hit || (m7_hit && !rx_sh_ff[0]))
                  state_ff <= ST_DATA;
               else if (hdr_hit && !rx_sh_ff[0])
                  state_ff <= ST_ADDR2;
               else
                  state_ff <= ST_SKIP;
            ST_ADDR2:
               state_ff <= m10_hit ? ST_DATA : ST_SKIP;
            ST_IDLE, ST_DATA, ST_SKIP:
               state_ff <= state_ff;
         endcase
      end
   end

   // Receive buffer and overflow
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rx_buf_ff  <= 8'h00;
         rx_full_ff <= 1'b0;
      end
      else if (byte_done && data_hit && !rx_full_ff)
      begin
         rx_buf_ff  <= rx_sh_ff;
         rx_full_ff <= 1'b1;
      end
      else if (rd_rx)
         rx_full_ff <= 1'b0;
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         ov_ff <= 1'b0;
      else if (byte_done && data_hit && rx_full_ff)
         ov_ff <= 1'b1;
      else if (wr_status && !reg_wdata_i[`I2SF_ST_OV])
         ov_ff <= 1'b0;
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         write_collision_ff <= 1'b0;
      else if (wr_tx && tx_act_ff)
         write_collision_ff <= 1'b1;
      else if (wr_status && !reg_wdata_i[`I2SF_ST_WRITE_COLLISION])
         write_collision_ff <= 1'b0;
   end

   // Master transmit: shift register and progress
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tx_sh_ff  <= 8'h00;
         tx_act_ff <= 1'b0;
      end
      else if (tx_go)
      begin
         tx_sh_ff  <= reg_wdata_i[7:0];
         tx_act_ff <= 1'b1;
      end
      else if (frame_edge || collide || ack_end)
         tx_act_ff <= 1'b0;
      else if (cnd.fall && tx_act_ff && cnt_ff < `I2SF_CNT_BYTE)
         tx_sh_ff  <= {tx_sh_ff[6:0], 1'b0};
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         ack_ff <= 1'b0;
      else if (cnd.rise && tx_act_ff && cnt_ff == `I2SF_CNT_BYTE)
         ack_ff <= pin_s.sda;
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         bcl_ff <= 1'b0;
      else if (collide)
         bcl_ff <= 1'b1;
      else if (wr_status && !reg_wdata_i[`I2SF_ST_BCL])
         bcl_ff <= 1'b0;
   end

   // Data line drive: master bits, then our acknowledge as slave
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         oe_ff <= 1'b0;
      else if (tx_go)
         oe_ff <= !reg_wdata_i[7];
      else if (frame_edge || collide || ack_end)
         oe_ff <= 1'b0;
      else if (byte_done)
         oe_ff <= !tx_act_ff && do_ack;
      else if (cnd.fall && tx_act_ff && cnt_ff < `I2SF_CNT_BYTE)
         oe_ff <= !tx_sh_ff[6];
   end

   // Address and condition flags
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         gc_ff    <= 1'b0;
         ten_bit_match_ff <= 1'b0;
      end
      else if (cnd.stop)
      begin
         gc_ff    <= 1'b0;
         ten_bit_match_ff <= 1'b0;
      end
      else if (byte_done)
      begin
         if (gc_hit)
            gc_ff <= 1'b1;
         if (m10_hit)
            ten_bit_match_ff <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         da_ff <= 1'b0;
      else if (byte_done && addr_hit)
         da_ff <= 1'b0;
      else if (byte_done && data_hit)
         da_ff <= 1'b1;
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         p_ff <= 1'b0;
      else if (cnd.stop)
         p_ff <= 1'b1;
      else if (cnd.start)
         p_ff <= 1'b0;
   end

   always_comb
   begin
      status_vec                 = '0;
      status_vec[`I2SF_ST_ACK]   = ack_ff;
      status_vec[`I2SF_ST_TXACT] = tx_act_ff;
      status_vec[`I2SF_ST_BCL]   = bcl_ff;
      status_vec[`I2SF_ST_GC]    = gc_ff;
      status_vec[`I2SF_ST_TEN_BIT_MATCH] = ten_bit_match_ff;
      status_vec[`I2SF_ST_WRITE_COLLISION] = write_collision_ff;
      status_vec[`I2SF_ST_OV]    = ov_ff;
      status_vec[`I2SF_ST_DA]    = da_ff;
      status_vec[`I2SF_ST_P]     = p_ff;
   end

   // Configuration registers
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ctrl_ff <= `I2SF_CTRL_RST;
         own_ff  <= `I2SF_OWN_RST;
      end
      else if (reg_wr_i && reg_addr_i == `I2SF_REG_CTRL)
         ctrl_ff <= reg_wdata_i[`I2SF_CTRL_W-1:0];
      else if (reg_wr_i && reg_addr_i == `I2SF_REG_OWN)
         own_ff  <= reg_wdata_i[`I2SF_OWN_W-1:0];
   end

   // Interrupt events; a new event beats a clear in the same cycle
   always_comb
   begin
      evt.stop       = cnd.stop;
      evt.rx_data    = byte_done && data_hit;
      evt.addr_match = byte_done && addr_hit;
      evt.collision  = collide;
      evt.tx_done    = ack_end && tx_act_ff;
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         istat_ff <= '0;
      else if (reg_wr_i && reg_addr_i == `I2SF_REG_ICLR)
         istat_ff <= (istat_ff & ~reg_wdata_i[`I2SF_EVT_W-1:0]) | evt;
      else
         istat_ff <= istat_ff | evt;
   end

   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         ien_ff <= '0;
      else if (reg_wr_i && reg_addr_i == `I2SF_REG_IEN)
         ien_ff <= reg_wdata_i[`I2SF_EVT_W-1:0];
   end

   // Read data stands for exactly the cycle after the strobe
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_ff <= '0;
      else if (!reg_rd_i)
         rdata_ff <= '0;
      else
      begin
         unique case (reg_addr_i)
            `I2SF_REG_STATUS: rdata_ff <= status_vec;
            `I2SF_REG_CTRL:   rdata_ff <= {13'h0000, ctrl_ff};
            `I2SF_REG_OWN:    rdata_ff <= {6'h00, own_ff};
            `I2SF_REG_RX:     rdata_ff <= {8'h00, rx_buf_ff};
            `I2SF_REG_ISTAT:  rdata_ff <= {11'h000, istat_ff};
            `I2SF_REG_IEN:    rdata_ff <= {11'h000, ien_ff};
            default:          rdata_ff <= '0;
         endcase
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign irq_o       = |(istat_ff & ien_ff);
   assign sda_o       = 1'b0;
   assign sda_oe_o    = oe_ff;
endmodule : i2sf_status

// ===== hw/i2sf_regs.svh
// Register map, field positions and bus constants of the status-flag block
`ifndef I2SF_REGS_SVH
`define I2SF_REGS_SVH

`define I2SF_ADDR_W        3
`define I2SF_DATA_W        16
`define I2SF_CTRL_W        3
`define I2SF_OWN_W         10
`define I2SF_EVT_W         5

`define I2SF_REG_STATUS    3'h0
`define I2SF_REG_CTRL      3'h1
`define I2SF_REG_OWN       3'h2
`define I2SF_REG_TX        3'h3
`define I2SF_REG_RX        3'h4
`define I2SF_REG_ISTAT     3'h5
`define I2SF_REG_ICLR      3'h6
`define I2SF_REG_IEN       3'h7

`define I2SF_ST_ACK        15
`define I2SF_ST_TXACT      14
`define I2SF_ST_BCL        10
`define I2SF_ST_GC         9
`define I2SF_ST_TEN_BIT_MATCH      8
`define I2SF_ST_WRITE_COLLISION      7
`define I2SF_ST_OV         6
`define I2SF_ST_DA         5
`define I2SF_ST_P          4

`define I2SF_CTRL_MASTER   0
`define I2SF_CTRL_TEN      1
`define I2SF_CTRL_GCEN     2

`define I2SF_CTRL_RST      3'h0
`define I2SF_OWN_RST       10'h000
`define I2SF_CNT_ZERO      4'h0
`define I2SF_CNT_BYTE      4'h8
`define I2SF_CNT_ACK       4'h9
`define I2SF_GC_ADDR       8'h00
`define I2SF_TEN_HDR       5'h1E

`endif

// ===== hw/i2sf_pkg.sv
// Types shared by the status-flag block and its helpers
package i2sf_pkg;

   typedef struct packed {
      logic scl;
      logic sda;
   } i2sf_line_t;

   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } i2sf_cond_t;

   typedef struct packed {
      logic stop;
      logic rx_data;
      logic addr_match;
      logic collision;
      logic tx_done;
   } i2sf_evt_t;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_ADDR  = 5'b00010,
      ST_ADDR2 = 5'b00100,
      ST_DATA  = 5'b01000,
      ST_SKIP  = 5'b10000
   } i2sf_state_t;

endpackage : i2sf_pkg

// ===== hw/i2sf_sync.sv
// Multi-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module i2sf_sync
#(
   parameter int W      = 2,
   parameter int STAGES = 2
)
(
   input  wire logic         core_clk_i, // Core clock
   input  wire logic         rst_i,      // Async reset, active high
   input  wire logic [W-1:0] async_i,    // Raw pin levels
   output logic      [W-1:0] sync_o      // Synchronised levels
);
   generate
      if (STAGES < 2 || W < 1)
      begin : g_bad
         $error("i2sf_sync needs at least two stages");
      end
   endgenerate

   genvar b;
   generate
      for (b = 0; b < W; b++)
      begin : g_bit
         logic [STAGES-1:0] chain_ff;
         always_ff @(posedge core_clk_i or posedge rst_i)
         begin
            if (rst_i)
               chain_ff <= '1;
            else
               chain_ff <= {chain_ff[STAGES-2:0], async_i[b]};
         end
         assign sync_o[b] = chain_ff[STAGES-1];
      end
   endgenerate
endmodule : i2sf_sync

// ===== hw/i2sf_cond.sv
// Edge and Start/Stop detector on synchronised bus lines
`timescale 1ns/1ps
module i2sf_cond
   import i2sf_pkg::*;
(
   input  wire logic       core_clk_i, // Core clock
   input  wire logic       rst_i,      // Async reset, active high
   input  wire i2sf_line_t line_i,     // Synchronised clock and data
   output i2sf_cond_t      cond_o      // One-cycle bus events
);
   i2sf_line_t prev_ff;

   // Idle bus is high on both wires, so no event fires after reset
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
         prev_ff <= '{scl: 1'b1, sda: 1'b1};
      else
         prev_ff <= line_i;
   end

   always_comb
   begin
      cond_o.rise  = line_i.scl & ~prev_ff.scl;
      cond_o.fall  = ~line_i.scl & prev_ff.scl;
      cond_o.start = line_i.scl & prev_ff.scl & prev_ff.sda & ~line_i.sda;
      cond_o.stop  = line_i.scl & prev_ff.scl & ~prev_ff.sda & line_i.sda;
   end
endmodule : i2sf_cond

// ===== verif/i2sf_chk.sv
// Port assertions for the status-flag block
`timescale 1ns/1ps
`include "i2sf_regs.svh"
module i2sf_chk
(
   input  wire logic                    core_clk_i,  // Core clock
   input  wire logic                    rst_i,       // Async reset
   input  wire logic                    scl_i,       // Bus clock pin
   input  wire logic                    sda_i,       // Bus data pin
   input  wire logic                    sda_o,       // Data drive value
   input  wire logic                    sda_oe_o,    // Data drive enable
   input  wire logic [`I2SF_ADDR_W-1:0] reg_addr_i,  // Register index
   input  wire logic [`I2SF_DATA_W-1:0] reg_wdata_i, // Write data
   input  wire logic                    reg_wr_i,    // Write strobe
   input  wire logic                    reg_rd_i,    // Read strobe
   input  wire logic [`I2SF_DATA_W-1:0] reg_rdata_o, // Read data
   input  wire logic                    irq_o        // Interrupt
);
   logic       scl_q_ff;
   logic       sda_q_ff;
   logic       stop_ff;
   logic [3:0] age_ff;
   logic [4:0] ien_ff;
   wire        bus_cond = scl_q_ff & scl_i & (sda_q_ff ^ sda_i);
   wire        st_rd = reg_rd_i & (reg_addr_i == `I2SF_REG_STATUS);

   // Age of last pin-level Start/Stop; design lags about three cycles
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         stop_ff  <= 1'b0;
         age_ff   <= 4'hF;
         ien_ff   <= 5'h00;
      end
      else
      begin
         scl_q_ff <= scl_i;
         sda_q_ff <= sda_i;
         if (bus_cond)
            stop_ff <= sda_i;
         if (bus_cond)
            age_ff <= 4'h0;
         else if (age_ff != 4'hF)
            age_ff <= age_ff + 4'h1;
         if (reg_wr_i && reg_addr_i == `I2SF_REG_IEN)
            ien_ff <= reg_wdata_i[4:0];
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   chk_reset_clear: assert property (
      $past(rst_i) && st_rd |=> reg_rdata_o == 16'h0000)
      else $error("status not clear after reset");
   chk_gap_zero: assert property (
      st_rd |=> reg_rdata_o[13:11] == 3'h0)
      else $error("unused status bits not zero");
   chk_stop_last: assert property (
      st_rd && age_ff >= 4'h8 |=> reg_rdata_o[`I2SF_ST_P] == $past(stop_ff))
      else $error("stop flag disagrees with last bus condition");
   chk_stop_clears: assert property (
      st_rd && age_ff >= 4'h8 && stop_ff |=> reg_rdata_o[9:8] == 2'b00)
      else $error("address flags survive a stop");
   chk_rdata_idle: assert property (
      !reg_rd_i |=> reg_rdata_o == 16'h0000)
      else $error("read data outside read answer");
   chk_wo_zero: assert property (
      reg_rd_i && reg_addr_i == `I2SF_REG_ICLR |=> reg_rdata_o == 16'h0000)
      else $error("write-only register read nonzero");
   chk_irq_masked: assert property (
      ien_ff == 5'h00 |-> !irq_o)
      else $error("interrupt while all sources masked");
   chk_irq_level: assert property (
      reg_rd_i && reg_addr_i == `I2SF_REG_ISTAT |=>
      (|(reg_rdata_o[4:0] & $past(ien_ff))) == $past(irq_o))
      else $error("interrupt level disagrees with status");
   chk_drive_low: assert property (
      sda_oe_o |-> sda_o == 1'b0)
      else $error("data pin driven high");

   cover property (st_rd ##1 reg_rdata_o[`I2SF_ST_BCL]);
   cover property (st_rd ##1 reg_rdata_o[`I2SF_ST_OV]);
   cover property (irq_o);
endmodule : i2sf_chk

bind i2sf_status i2sf_chk i2sf_chk_i (.core_clk_i, .rst_i, .scl_i, .sda_i,
   .sda_o, .sda_oe_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
   .reg_rdata_o, .irq_o);

// ===== verif/i2sf_bus_model.sv
// Remote bus party: makes the bus clock, pulls data low
`timescale 1ns/1ps
module i2sf_bus_model
(
   input  wire logic core_clk_i, // Core clock, task alignment only
   input  wire logic sda_i,      // Wired data level
   output logic      scl_o,      // Bus clock, idle high
   output logic      sda_low_o   // Pull data low
);
   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // Offset of 7 ns keeps stop_c and xfer edges off core edges; start_c moves its lines on core rising edges
   task automatic start_c;
      #7 sda_low_o = 1'b0;
      #33 scl_o = 1'b1;
      #120 sda_low_o = 1'b1;
      #120 scl_o = 1'b0;
      #160 @(posedge core_clk_i);
   endtask : start_c
   task automatic stop_c;
      #7 sda_low_o = 1'b1;
      #200 scl_o = 1'b1;
      #120 sda_low_o = 1'b0;
      #320 @(posedge core_clk_i);
   endtask : stop_c
   // Long low phase leaves the slow sampler data setup time
   task automatic xfer(input logic [8:0] drv, output logic [8:0] got);
      #7;
      for (int i = 8; i >= 0; i--)
      begin
         #40 sda_low_o = ~drv[i];
         #200 scl_o = 1'b1;
         #40 got[i] = sda_i;
         #40 scl_o = 1'b0;
      end
      #40 sda_low_o = 1'b0;
      #160 @(posedge core_clk_i);
   endtask : xfer
endmodule : i2sf_bus_model

// ===== verif/i2sf_status_test.sv
// Self-checking bench for the status-flag block
`timescale 1ns/1ps
`include "i2sf_regs.svh"
module i2sf_status_test;
   typedef struct {logic [15:0] e; logic [15:0] m; logic [2:0] a;} tb_note_t;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        rd_d = 1'b0;
   logic [2:0]  addr = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic        irq, oe, dval, scl, m_low;
   wire         sda = ~(m_low | (oe & ~dval));
   tb_note_t    q[$];
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          n_seed;
   logic [8:0]  got;
   logic [7:0]  b;
   logic [7:0]  dat [3];
   logic [9:0]  own;
   logic        nack;

   i2sf_status i2sf_status_i (.core_clk_i(clk), .rst_i(rst), .scl_i(scl),
      .sda_i(sda), .sda_o(dval), .sda_oe_o(oe), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .irq_o(irq));
   i2sf_bus_model i2sf_bus_model_i (.core_clk_i(clk), .sda_i(sda),
      .scl_o(scl), .sda_low_o(m_low));

   always #20 clk = ~clk;

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] s);
      n_compared++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic give_verdict;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   task automatic wr_r(input logic [2:0] a, input logic [15:0] d);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wr_r
   task automatic rd_r(input logic [2:0] a, input logic [15:0] e,
                       input logic [15:0] m);
      q.push_back('{e, m, a});
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask : rd_r
   task automatic st(input logic [15:0] e, input logic [15:0] m);
      rd_r(`I2SF_REG_STATUS, e, m | 16'h380F);
   endtask : st
   task automatic irq_is(input logic e);
      @(negedge clk);
      chk("irq", {15'h0000, e}, {15'h0000, irq});
      @(posedge clk);
   endtask : irq_is

   // Read answer stands only in the cycle after the strobe
   always @(posedge clk)
      rd_d <= rd;
   always @(negedge clk)
      if (rd_d === 1'b1)
      begin
         tb_note_t n;
         n = q.pop_front();
         chk($sformatf("reg%0d", n.a), n.e & n.m, rdata & n.m);
      end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   initial
   begin
      n_seed = $urandom(81);
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      st(16'h0000, 16'hFFFF);
      rd_r(`I2SF_REG_ISTAT, 16'h0000, 16'hFFFF);
      rd_r(`I2SF_REG_ICLR, 16'h0000, 16'hFFFF);
      wr_r(`I2SF_REG_CTRL, 16'h0001);
      for (int k = 0; k < 2; k++)
      begin
         b = 8'($urandom());
         nack = k[0];
         i2sf_bus_model_i.start_c();
         wr_r(`I2SF_REG_TX, {8'h00, b});
         st(16'h4000, 16'h4000);
         wr_r(`I2SF_REG_TX, {8'h00, ~b});
         st(16'h4080, 16'h4080);
         i2sf_bus_model_i.xfer({8'hFF, nack}, got);
         chk("tx byte", {8'h00, b}, {8'h00, got[8:1]});
         st({nack, 15'h0080}, 16'hC080);
         wr_r(`I2SF_REG_STATUS, 16'hFF7F);
         st(16'h0000, 16'h0080);
         i2sf_bus_model_i.stop_c();
      end
      wr_r(`I2SF_REG_IEN, 16'h0002);
      i2sf_bus_model_i.start_c();
      b = 8'($urandom()) | 8'h80;
      wr_r(`I2SF_REG_TX, {8'h00, b});
      i2sf_bus_model_i.xfer({1'b0, 8'hFF}, got);
      st(16'h0400, 16'h4400);
      rd_r(`I2SF_REG_ISTAT, 16'h0002, 16'h0002);
      irq_is(1'b1);
      wr_r(`I2SF_REG_IEN, 16'h0000);
      irq_is(1'b0);
      wr_r(`I2SF_REG_ICLR, 16'h0002);
      wr_r(`I2SF_REG_IEN, 16'h0002);
      irq_is(1'b0);
      wr_r(`I2SF_REG_STATUS, 16'hFBFF);
      st(16'h0000, 16'h0400);
      i2sf_bus_model_i.stop_c();
      own = 10'($urandom_range(32'h77, 32'h01));
      wr_r(`I2SF_REG_CTRL, 16'h0004);
      wr_r(`I2SF_REG_OWN, {6'h00, own});
      i2sf_bus_model_i.start_c();
      st(16'h0000, 16'h0010);
      i2sf_bus_model_i.xfer({own[6:0], 2'b01}, got);
      chk("addr ack", 16'h0000, {15'h0000, got[0]});
      st(16'h0000, 16'h0020);
      for (int k = 0; k < 3; k++)
      begin
         dat[k] = 8'($urandom());
         i2sf_bus_model_i.xfer({dat[k], 1'b1}, got);
         chk("data ack", {15'h0000, k == 2}, {15'h0000, got[0]});
         st({9'h000, k == 2, 6'h20}, 16'h0060);
         if (k == 0)
            rd_r(`I2SF_REG_RX, {8'h00, dat[0]}, 16'h00FF);
      end
      i2sf_bus_model_i.stop_c();
      st(16'h0010, 16'h0310);
      rd_r(`I2SF_REG_RX, {8'h00, dat[1]}, 16'h00FF);
      wr_r(`I2SF_REG_STATUS, 16'hFFBF);
      st(16'h0000, 16'h0040);
      i2sf_bus_model_i.start_c();
      i2sf_bus_model_i.xfer({8'h00, 1'b1}, got);
      chk("gc ack", 16'h0000, {15'h0000, got[0]});
      st(16'h0200, 16'h0200);
      i2sf_bus_model_i.stop_c();
      st(16'h0010, 16'h0210);
      own = 10'($urandom());
      wr_r(`I2SF_REG_CTRL, 16'h0002);
      wr_r(`I2SF_REG_OWN, {6'h00, own});
      rd_r(`I2SF_REG_CTRL, 16'h0002, 16'hFFFF);
      rd_r(`I2SF_REG_OWN, {6'h00, own}, 16'hFFFF);
      rd_r(`I2SF_REG_IEN, 16'h0002, 16'hFFFF);
      i2sf_bus_model_i.start_c();
      i2sf_bus_model_i.xfer({5'h1E, own[9:8], 2'b01}, got);
      i2sf_bus_model_i.xfer({own[7:0], 1'b1}, got);
      chk("ten ack", 16'h0000, {15'h0000, got[0]});
      st(16'h0100, 16'h0100);
      i2sf_bus_model_i.stop_c();
      st(16'h0010, 16'h0110);
      // Sticky events of the whole run; only the collision was cleared
      rd_r(`I2SF_REG_ISTAT, 16'h001D, 16'h001F);
      repeat (4) @(posedge clk);
      give_verdict();
   end
endmodule : i2sf_status_test
